// file: core/rls_top.sv
// Radio link control and sleep sequencer: radio pins, power-up, serial access, sleep.
// Assumes the power manager, slow clock and radio pins are outside; slow clock is async.
//
// Functional notes
// R1 - Fast-write enable lets the header carry a write-only register address.
// R2 - Power and output fast writes send just 3 address and 5 data bits.
// R3 - Normal read and write frames stay usable while fast write is on.
// R4 - A 32-bit register takes two writes, high word then low word.
// R5 - At least two serial clocks separate the two word writes.
// R6 - Reading a 32-bit radio register returns a word count, 0 or 1.
// R7 - Init writes 32-bit registers 17,15,14,12..4,2,1 in that order.
// R8 - After reset modem data is high; chip-enable, sync, serial data float.
// R9 - First radio type starts its oscillator on modem data high.
// R10 - First radio type leaves power-up mode when chip-enable rises.
// R11 - Second radio type raises power-good after four reference clocks.
// R12 - After power-good drive chip-enable high and do all radio writes.
// R13 - Modem data goes low when initialisation is finished.
// R14 - Chip-enable low forces radio sleep at any time.
// R15 - Radio restarts its oscillator when chip-enable rises in sleep.
// R16 - In sleep only the M and N slow-clock counters run.
// R17 - Before sleep registers move to the local domain; CPU locked out.
// R18 - With gating enabled, request it; next slow edge stops local clocks.
// R19 - After M+1 slow cycles the gating request drops.
// R20 - After N+1 more slow cycles local clocks restart.
// R21 - Sleep end pulses wake-up; domains return once gating is disabled.
// R22 - Normal frame: 3-bit header, rw, 5-bit address, 16 data, MSB first.
// R23 - Data changes on falling serial clock; load strobe commits it.
// R24 - M and N are latched at sleep entry and frozen during sleep.
// R25 - Word gap is counted in half serial clock periods.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module rls_top (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [31:0]      o_rdata,
	input  wire logic        i_slow_clk,
	input  wire logic        i_power_good,
	input  wire logic        i_hcc_en,
	input  wire logic        i_serial_link_data,
	output logic             o_sclk,
	output logic             o_serial_link_data,
	output logic             o_serial_link_data_oe_n,
	output logic             o_sle,
	output logic             o_ce,
	output logic             o_ce_oe_n,
	output logic             o_sync,
	output logic             o_sync_oe_n,
	output logic             o_modem_data,
	output logic             o_clk_gate_req,
	output logic             o_llc_clk_on,
	output logic             o_domain_local,
	output logic             o_wakeup
);
	import rls_pkg::*;

	typedef enum logic [1:0] {PW_RESET, PW_INIT, PW_IDLE} rls_pwr_e;
	typedef enum logic [2:0] {SL_IDLE, SL_SWITCH, SL_REQ, SL_MCNT, SL_NCNT, SL_WAKE, SL_BACK} rls_slp_e;

	rls_pwr_e    pw_state;
	rls_slp_e    sl_state;
	logic        fast_en;
	logic        init_done;
	logic        pup_go;
	logic        sync_val;
	logic        sync_en;
	logic        sleep_go;
	logic [7:0]  div;
	logic [15:0] m_reg;
	logic [15:0] n_reg;
	logic [15:0] m_lat;
	logic [15:0] n_lat;
	logic [15:0] cnt;
	logic [31:0] data_reg;
	logic [3:0]  ord_idx;
	logic        ord_err;
	logic        wake_flag;
	logic        sl_s1, sl_s2, sl_s3;
	logic        pg_s1, pg_sync;
	logic        sd_s1, sd_sync;
	logic        slow_rise;
	logic        ser_busy;
	logic [15:0] ser_rdata;
	logic        wr_ok;
	logic        cmd_wr;
	logic        cmd_go;
	logic        kind_ok;
	logic        order_ok;
	logic        order_bad;
	rls_frame_s  frame;

	// Expected address of each 32-bit register during init
	function automatic logic [4:0] order_addr(input logic [3:0] idx);
		case (idx)
			4'h0:    order_addr = 5'h11;
			4'h1:    order_addr = 5'h0f;
			4'h2:    order_addr = 5'h0e;
			4'hc:    order_addr = 5'h02;
			4'hd:    order_addr = 5'h01;
			default: order_addr = 5'(5'h0f - {1'b0, idx});
		endcase
	endfunction : order_addr

	////////////////////////////////////////////////////////////////////////////
	// Synchronisers for pins from outside the core domain

	// Slow clock three flops with edge detect; power-good and serial data two flops each
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sl_s1 <= 1'b0;
			sl_s2 <= 1'b0;
			sl_s3 <= 1'b0;
			pg_s1 <= 1'b0;
			pg_sync <= 1'b0;
			sd_s1 <= 1'b0;
			sd_sync <= 1'b0;
		end else begin
			sl_s1 <= i_slow_clk;
			sl_s2 <= sl_s1;
			sl_s3 <= sl_s2;
			pg_s1 <= i_power_good;
			pg_sync <= pg_s1;
			sd_s1 <= i_serial_link_data;
			sd_sync <= sd_s1;
		end
	end

	assign slow_rise = sl_s2 && !sl_s3;

	////////////////////////////////////////////////////////////////////////////
	// Command decode

	// CPU writes are only honoured while registers sit in the system domain
	assign wr_ok = i_wr && !o_domain_local; // see R17
	assign cmd_wr = wr_ok && i_addr == RLS_CMD;
	assign frame.kind = rls_kind_e'(i_wdata[7:6]);
	assign frame.rw = i_wdata[5] && frame.kind == K_NORMAL;
	assign frame.addr = i_wdata[4:0];
	assign frame.data = data_reg;
	// Fast frames need fast mode; normal frames always pass
	assign kind_ok = frame.kind == K_NORMAL || frame.kind == K_WIDE || fast_en; // see R1 R3
	assign order_ok = pw_state != PW_INIT || frame.kind != K_WIDE
		|| ord_idx >= 4'(RLS_ORD_NUM) || frame.addr == order_addr(ord_idx);
	assign order_bad = cmd_wr && !ser_busy && kind_ok && pw_state != PW_RESET && !order_ok;
	assign cmd_go = cmd_wr && !ser_busy && kind_ok && order_ok && pw_state != PW_RESET; // see R12

	////////////////////////////////////////////////////////////////////////////
	// Software registers

	// Control, divider, sleep counts and data word
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			fast_en <= 1'b0;
			init_done <= 1'b0;
			pup_go <= 1'b0;
			sync_val <= 1'b0;
			sync_en <= 1'b0;
			sleep_go <= 1'b0;
			div <= RLS_DIV_RST;
			m_reg <= 16'h0000;
			n_reg <= 16'h0000;
			data_reg <= 32'h0000_0000;
		end else begin
			sleep_go <= 1'b0;
			if (wr_ok) begin
				case (i_addr)
					RLS_CTRL: begin
						fast_en <= i_wdata[CT_FAST];
						init_done <= i_wdata[CT_INIT];
						sleep_go <= i_wdata[CT_SLEEP];
						pup_go <= i_wdata[CT_PUP];
						sync_val <= i_wdata[CT_SYNCV];
						sync_en <= i_wdata[CT_SYNCE];
					end
					RLS_DATA:  data_reg <= i_wdata;
					RLS_SLP_M: m_reg <= i_wdata[15:0];
					RLS_SLP_N: n_reg <= i_wdata[15:0];
					RLS_DIV:   div <= i_wdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// Sticky flags, write one to clear, a new event wins
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ord_err <= 1'b0;
			wake_flag <= 1'b0;
		end else begin
			if (order_bad)
				ord_err <= 1'b1; // see R7
			else if (wr_ok && i_addr == RLS_STATUS && i_wdata[ST_OERR])
				ord_err <= 1'b0;
			if (sl_state == SL_BACK && !i_hcc_en)
				wake_flag <= 1'b1; // see R21
			else if (wr_ok && i_addr == RLS_STATUS && i_wdata[ST_WAKE])
				wake_flag <= 1'b0;
		end
	end

	// Init order tracker for 32-bit registers
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			ord_idx <= 4'h0;
		else if (cmd_go && frame.kind == K_WIDE && pw_state == PW_INIT && ord_idx < 4'(RLS_ORD_NUM))
			ord_idx <= ord_idx + 4'h1; // see R7
	end

	// Read port, data valid the cycle after the strobe only
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_rdata <= 32'h0000_0000;
		end else begin
			o_rdata <= 32'h0000_0000;
			if (i_rd) begin
				case (i_addr)
					RLS_CTRL:   o_rdata <= o_domain_local ? 32'h0000_0000
						: {26'h000_0000, sync_en, sync_val, pup_go, 1'b0, init_done, fast_en};
					RLS_DATA:   o_rdata <= o_domain_local ? 32'h0000_0000 : {16'h0000, ser_rdata}; // see R6
					RLS_SLP_M:  o_rdata <= {16'h0000, m_reg};
					RLS_SLP_N:  o_rdata <= {16'h0000, n_reg};
					RLS_DIV:    o_rdata <= {24'h00_0000, div};
					RLS_STATUS: o_rdata <= {20'h0_0000, ord_idx, 3'h0, ord_err, wake_flag,
						o_domain_local, pg_sync, ser_busy};
					default:    o_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Radio power-up

	// Pins float at reset, modem data held high to start the oscillator
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pw_state <= PW_RESET;
			o_modem_data <= 1'b1; // see R8
			o_ce_oe_n <= 1'b1;
			o_sync_oe_n <= 1'b1;
			o_sync <= 1'b0;
		end else begin
			if (pw_state != PW_RESET) begin
				o_sync_oe_n <= !sync_en;
				o_sync <= sync_val;
			end
			case (pw_state)
				PW_RESET: begin
					if (pg_sync || pup_go) begin
						o_ce_oe_n <= 1'b0; // see R12
						pw_state <= PW_INIT;
					end
				end
				PW_INIT: begin
					if (init_done && !ser_busy) begin
						o_modem_data <= 1'b0; // see R13
						pw_state <= PW_IDLE;
					end
				end
				PW_IDLE: ;
				default: pw_state <= PW_RESET;
			endcase
		end
	end

	// Chip-enable follows power-up and is pulled low across the gated sleep
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			o_ce <= 1'b0;
		else if (sl_state == SL_SWITCH && i_hcc_en)
			o_ce <= 1'b0; // see R14
		else if (pw_state == PW_RESET)
			o_ce <= pg_sync || pup_go;
		else if (sl_state == SL_WAKE || sl_state == SL_IDLE)
			o_ce <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////
	// Sleep sequencer

	// Domain switch, gating request, M and N counts, wake-up
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sl_state <= SL_IDLE;
			m_lat <= 16'h0000;
			n_lat <= 16'h0000;
			cnt <= 16'h0000;
			o_domain_local <= 1'b0;
			o_clk_gate_req <= 1'b0;
			o_llc_clk_on <= 1'b1;
			o_wakeup <= 1'b0;
		end else begin
			o_wakeup <= 1'b0;
			case (sl_state)
				SL_IDLE: begin
					if (sleep_go && pw_state == PW_IDLE && !ser_busy) begin
						m_lat <= m_reg; // see R24
						n_lat <= n_reg;
						o_domain_local <= 1'b1; // see R17
						sl_state <= SL_SWITCH;
					end
				end
				SL_SWITCH: begin
					if (i_hcc_en) begin
						o_clk_gate_req <= 1'b1; // see R18
						sl_state <= SL_REQ;
					end
				end
				SL_REQ: begin
					if (slow_rise) begin
						o_llc_clk_on <= 1'b0; // see R16 R18
						cnt <= 16'h0000;
						sl_state <= SL_MCNT;
					end
				end
				SL_MCNT: begin
					if (slow_rise && cnt == m_lat) begin
						o_clk_gate_req <= 1'b0; // see R19
						cnt <= 16'h0000;
						sl_state <= SL_NCNT;
					end else if (slow_rise) begin
						cnt <= cnt + 16'h0001;
					end
				end
				SL_NCNT: begin
					if (slow_rise && cnt == n_lat) begin
						o_llc_clk_on <= 1'b1; // see R20
						sl_state <= SL_WAKE;
					end else if (slow_rise) begin
						cnt <= cnt + 16'h0001;
					end
				end
				SL_WAKE: begin
					o_wakeup <= 1'b1; // see R21
					sl_state <= SL_BACK;
				end
				SL_BACK: begin
					if (!i_hcc_en) begin
						o_domain_local <= 1'b0; // see R21
						sl_state <= SL_IDLE;
					end
				end
				default: sl_state <= SL_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Serial engine

	rls_serial u_serial (
		.i_core_clk  (i_core_clk),
		.i_arst_n    (i_arst_n),
		.i_start     (cmd_go),
		.i_frame     (frame),
		.i_div       (div),
		.i_serial_link_data      (sd_sync),
		.o_sclk      (o_sclk),
		.o_serial_link_data      (o_serial_link_data),
		.o_serial_link_data_oe_n (o_serial_link_data_oe_n),
		.o_sle       (o_sle),
		.o_busy      (ser_busy),
		.o_done      (),
		.o_rdata     (ser_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_reset_pins_free: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R8
		pw_state == PW_RESET |-> o_modem_data && o_ce_oe_n && o_serial_link_data_oe_n)
		else $error("radio pins driven before power-up");
	a_ce_after_good: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R12
		pw_state == PW_RESET && pg_sync |=> !o_ce_oe_n && o_ce)
		else $error("chip-enable not raised after power-good");
	a_modem_low_init: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R13
		pw_state == PW_INIT && init_done && !ser_busy |=> !o_modem_data ##1 !o_modem_data)
		else $error("modem data not lowered after init");
	a_gate_stops_clk: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R18
		sl_state == SL_REQ && slow_rise |=> !o_llc_clk_on && o_clk_gate_req)
		else $error("local clocks not stopped on slow edge");
	a_gate_drop_m: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R19
		sl_state == SL_MCNT && slow_rise && cnt == m_lat |=> !o_clk_gate_req && !o_llc_clk_on)
		else $error("gating request not dropped after M count");
	a_clk_on_n: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R20 R21
		sl_state == SL_NCNT && slow_rise && cnt == n_lat |=> o_llc_clk_on ##1 o_wakeup)
		else $error("clocks or wake-up missing after N count");
	a_cpu_locked: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R17
		o_domain_local && i_wr |=> $stable(m_reg) && $stable(n_reg) && $stable(data_reg))
		else $error("CPU write reached local-domain registers");
	a_counts_frozen: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R24
		sl_state != SL_IDLE |=> $stable(m_lat) && $stable(n_lat))
		else $error("sleep counts changed during sleep");
	a_ce_low_asleep: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R14
		!o_llc_clk_on |-> !o_ce)
		else $error("chip-enable high while local clocks stopped");
	a_fast_needs_en: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // see R1
		cmd_go && frame.kind inside {K_FAST16, K_FAST8} |-> fast_en)
		else $error("fast frame sent without fast mode");
endmodule : rls_top

// file: inc/rls_pkg.sv
// Constants and types shared by the radio link control and sleep block.
// Assumes a 125 MHz core clock and a plain address/strobe register port.
package rls_pkg;
	// Register map, byte addresses
	localparam logic [7:0] RLS_CTRL   = 8'h00;
	localparam logic [7:0] RLS_CMD    = 8'h04;
	localparam logic [7:0] RLS_DATA   = 8'h08;
	localparam logic [7:0] RLS_SLP_M  = 8'h0c;
	localparam logic [7:0] RLS_SLP_N  = 8'h10;
	localparam logic [7:0] RLS_STATUS = 8'h14;
	localparam logic [7:0] RLS_DIV    = 8'h18;
	// Control fields
	localparam int CT_FAST  = 0;
	localparam int CT_INIT  = 1;
	localparam int CT_SLEEP = 2;
	localparam int CT_PUP   = 3;
	localparam int CT_SYNCV = 4;
	localparam int CT_SYNCE = 5;
	// Status fields
	localparam int ST_BUSY  = 0;
	localparam int ST_PGOOD = 1;
	localparam int ST_LOCAL = 2;
	localparam int ST_WAKE  = 3;
	localparam int ST_OERR  = 4;
	localparam int ST_OIDX  = 8;
	// Frame layout
	localparam logic [2:0] RLS_HDR      = 3'h5;
	localparam int         RLS_NORM_LEN = 25;
	localparam int         RLS_F16_LEN  = 16;
	localparam int         RLS_F8_LEN   = 8;
	localparam int         RLS_RX_FIRST = 10;
	localparam int         RLS_ORD_NUM  = 14;
	// Timing
	localparam int         RLS_CLK_MHZ  = 125;
	localparam int         RLS_SCLK_KHZ = 4000;
	localparam logic [7:0] RLS_DIV_RST  = 8'((RLS_CLK_MHZ * 1000) / (2 * RLS_SCLK_KHZ) - 1);
	localparam int         RLS_GAP_SCLK = 2;
	localparam logic [2:0] RLS_GAP_HALF = 3'(2 * RLS_GAP_SCLK - 1);

	typedef enum logic [1:0] {K_NORMAL, K_FAST16, K_FAST8, K_WIDE} rls_kind_e;

	typedef struct packed {
		rls_kind_e   kind;
		logic        rw;
		logic [4:0]  addr;
		logic [31:0] data;
	} rls_frame_s;
endpackage : rls_pkg

// file: core/rls_serial.sv
// Three-wire serial engine: shifts one frame out, two for a wide write, optionally reads 16 bits back.
// Assumes i_serial_link_data is already synchronised to the core clock.
`timescale 1ns/1ps
module rls_serial (
	input  wire logic              i_core_clk,
	input  wire logic              i_arst_n,
	input  wire logic              i_start,
	input  wire rls_pkg::rls_frame_s i_frame,
	input  wire logic [7:0]        i_div,
	input  wire logic              i_serial_link_data,
	output logic                   o_sclk,
	output logic                   o_serial_link_data,
	output logic                   o_serial_link_data_oe_n,
	output logic                   o_sle,
	output logic                   o_busy,
	output logic                   o_done,
	output logic [15:0]            o_rdata
);
	import rls_pkg::*;

	typedef enum logic [1:0] {SS_IDLE, SS_SHIFT, SS_LOAD, SS_GAP} rls_ser_e;

	rls_ser_e   state;
	rls_frame_s fr;
	logic [7:0] div_cnt;
	logic [24:0] shreg;
	logic [4:0] left;
	logic [4:0] sent;
	logic       wide_hi;
	logic [2:0] gap;
	logic       tick;
	logic [24:0] img_first;
	logic [24:0] img_low;

	// Frame image, left aligned, MSB first
	function automatic logic [24:0] frame_bits(input rls_frame_s f, input logic lo);
		case (f.kind)
			K_FAST16: frame_bits = {f.addr[2:0], f.data[12:0], 9'h000};  // see R1
			K_FAST8:  frame_bits = {f.addr[2:0], f.data[4:0], 17'h0_0000}; // see R2
			K_WIDE:   frame_bits = {RLS_HDR, 1'b0, f.addr, lo ? f.data[15:0] : f.data[31:16]}; // see R4
			default:  frame_bits = {RLS_HDR, f.rw, f.addr, f.data[15:0]}; // see R22
		endcase
	endfunction : frame_bits

	function automatic logic [4:0] frame_len(input rls_kind_e k);
		case (k)
			K_FAST16: frame_len = 5'(RLS_F16_LEN - 1);
			K_FAST8:  frame_len = 5'(RLS_F8_LEN - 1);
			default:  frame_len = 5'(RLS_NORM_LEN - 1);
		endcase
	endfunction : frame_len

	assign tick = (div_cnt == 8'h00);

	// Frame images for the first word and for the low word of a wide write
	assign img_first = frame_bits(i_frame, 1'b0);
	assign img_low = frame_bits(fr, 1'b1); // see R4

	// Half period divider
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n)
			div_cnt <= 8'h00;
		else if (state == SS_IDLE || tick)
			div_cnt <= i_div;
		else
			div_cnt <= div_cnt - 8'h01;
	end

	// Shift sequencer; data changes on falling sclk, radio samples on rising
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= SS_IDLE;
			fr <= '0;
			shreg <= '0;
			left <= 5'h00;
			sent <= 5'h00;
			wide_hi <= 1'b0;
			gap <= 3'h0;
			o_sclk <= 1'b0;
			o_serial_link_data <= 1'b0;
			o_serial_link_data_oe_n <= 1'b1;
			o_sle <= 1'b0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
			o_rdata <= 16'h0000;
		end else begin
			o_done <= 1'b0;
			case (state)
				SS_IDLE: begin
					if (i_start) begin
						fr <= i_frame;
						shreg <= img_first << 1;
						o_serial_link_data <= img_first[24];
						o_serial_link_data_oe_n <= 1'b0;
						left <= frame_len(i_frame.kind);
						sent <= 5'h01;
						wide_hi <= (i_frame.kind == K_WIDE);
						o_busy <= 1'b1;
						state <= SS_SHIFT;
					end
				end
				SS_SHIFT: begin
					if (tick && !o_sclk) begin
						o_sclk <= 1'b1;
					end else if (tick) begin
						o_sclk <= 1'b0; // see R23
						if (fr.rw && sent >= 5'(RLS_RX_FIRST))
							o_rdata <= {o_rdata[14:0], i_serial_link_data};
						if (left == 5'h00) begin
							o_sle <= 1'b1; // see R23
							state <= SS_LOAD;
						end else begin
							left <= left - 5'h01;
							sent <= sent + 5'h01;
							if (fr.rw && sent >= 5'(RLS_RX_FIRST - 1))
								o_serial_link_data_oe_n <= 1'b1;
							else
								o_serial_link_data <= shreg[24];
							shreg <= shreg << 1;
						end
					end
				end
				SS_LOAD: begin
					if (tick && !o_sclk) begin
						o_sclk <= 1'b1;
					end else if (tick) begin
						o_sclk <= 1'b0;
						o_sle <= 1'b0;
						o_serial_link_data <= 1'b0;
						o_serial_link_data_oe_n <= 1'b0;
						if (wide_hi) begin
							gap <= RLS_GAP_HALF; // see R5 R25
							state <= SS_GAP;
						end else begin
							o_busy <= 1'b0;
							o_done <= 1'b1;
							state <= SS_IDLE;
						end
					end
				end
				SS_GAP: begin
					if (tick && gap != 3'h0) begin
						gap <= gap - 3'h1; // see R25
					end else if (tick) begin
						wide_hi <= 1'b0;
						shreg <= img_low << 1; // see R4
						o_serial_link_data <= img_low[24];
						left <= frame_len(fr.kind);
						sent <= 5'h01;
						state <= SS_SHIFT;
					end
				end
				default: state <= SS_IDLE;
			endcase
		end
	end

	a_sle_gap_quiet: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
		state == SS_GAP |-> !o_sle && !o_sclk) // see R5
		else $error("serial pins moved during word gap");
endmodule : rls_serial

// file: test/rls_radio.sv
// Radio model: captures serial frames, answers reads with a word count.
// Assumes it watches the block's serial pins; power-good rises after reset.
`timescale 1ns/1ps
module rls_radio (
	input  wire logic   i_core_clk,
	input  wire logic   i_arst_n,
	input  wire logic   i_sclk,
	input  wire logic   i_wire,
	input  wire logic   i_sle,
	input  wire logic   i_ce,
	input  wire logic   i_modem,
	output logic        o_osc,
	output logic        o_power_good,
	output logic        o_serial_link_data,
	output logic [31:0] o_frame,
	output int          o_len,
	output int          o_nf,
	output int          o_gap
);
	logic [31:0] sh, hi, done;
	logic [15:0] rv;
	logic        drv, last, norm;
	int          n, pg;
	time         t_end;
	initial begin
		sh = '0; hi = '0; done = '0; n = 0; o_nf = 0; drv = 0; o_gap = 0; norm = 0;
	end
	// Power-good a few clocks after reset, line hold
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) pg <= 0;
		else if (pg < 4) pg <= pg + 1;
		last <= i_wire;
	end
	assign o_power_good = (pg == 4);
	// Sample on rising clock, commit on load strobe
	always @(posedge i_sclk) begin
		if (i_sle) begin
			if (n == 25 && !sh[21]) begin
				done[sh[20:16]] = hi[sh[20:16]];
				hi[sh[20:16]] = ~hi[sh[20:16]];
			end
			o_frame = sh; o_len = n; o_nf++; n = 0; sh = '0; drv = 0; t_end = $time;
		end else begin
			if (n == 0 && o_nf > 0) o_gap = int'($time - t_end);
			sh = {sh[30:0], i_wire};
			n++;
			if (drv && n > 10) rv = rv << 1;
			if (n == 9 && sh[5]) begin
				drv = 1;
				rv = {15'h0, done[sh[4:0]]};
			end
		end
	end
	// Oscillator: modem data starts it, chip-enable rules once it has risen
	always @(posedge i_ce) norm = 1;
	assign o_osc = norm ? i_ce : i_modem;
	// Released line shows the inverse of the last level
	assign o_serial_link_data = drv ? rv[15] : ~last;
endmodule : rls_radio

// file: test/tb.sv
// Self-checking bench for the radio link control and sleep block.
// Assumes the radio model and a free-running 80 ns slow clock.
`timescale 1ns/1ps
module tb;
	import rls_pkg::*;
	logic        i_core_clk, i_arst_n, i_wr, i_rd, i_slow_clk, i_hcc_en, pg, r_serial_link_data, w_serial_link_data;
	logic [7:0]  i_addr;
	logic [31:0] i_wdata, o_rdata, frame, v;
	logic        o_sclk, o_serial_link_data, o_serial_link_data_oe_n, o_sle, o_ce, o_ce_oe_n, o_sync, o_sync_oe_n;
	logic        o_modem_data, o_clk_gate_req, o_llc_clk_on, o_domain_local, o_wakeup, osc;
	int          errors, checked, len, nf, gap, sc, k, s0;
	assign w_serial_link_data = o_serial_link_data_oe_n ? r_serial_link_data : o_serial_link_data;
	rls_top i_dut (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_slow_clk(i_slow_clk), .i_power_good(pg),
		.i_hcc_en(i_hcc_en), .i_serial_link_data(w_serial_link_data), .o_sclk(o_sclk), .o_serial_link_data(o_serial_link_data), .o_serial_link_data_oe_n(o_serial_link_data_oe_n),
		.o_sle(o_sle), .o_ce(o_ce), .o_ce_oe_n(o_ce_oe_n), .o_sync(o_sync), .o_sync_oe_n(o_sync_oe_n),
		.o_modem_data(o_modem_data), .o_clk_gate_req(o_clk_gate_req), .o_llc_clk_on(o_llc_clk_on),
		.o_domain_local(o_domain_local), .o_wakeup(o_wakeup));
	rls_radio i_radio (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_sclk(o_sclk), .i_wire(w_serial_link_data),
		.i_sle(o_sle), .o_power_good(pg), .o_serial_link_data(r_serial_link_data), .o_frame(frame), .o_len(len), .o_nf(nf),
		.o_gap(gap), .i_ce(o_ce), .i_modem(o_modem_data), .o_osc(osc));
	////////////////////////////////////////////////////////////////
	// Clocks and slow edge count
	initial begin
		i_core_clk = 0;
		forever #4 i_core_clk = ~i_core_clk;
	end
	initial begin
		i_slow_clk = 0;
		forever #40 i_slow_clk = ~i_slow_clk;
	end
	always @(posedge i_slow_clk) sc++;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_core_clk);
		i_wr <= 1; i_addr <= a; i_wdata <= d;
		@(posedge i_core_clk);
		i_wr <= 0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge i_core_clk);
		i_rd <= 1; i_addr <= a;
		@(posedge i_core_clk);
		i_rd <= 0;
		#1 v = o_rdata;
	endtask : rd
	// Send one frame, two for a wide write, and poll busy until it clears
	task automatic op(input logic [31:0] d, input logic [7:0] c);
		wr(RLS_DATA, d);
		wr(RLS_CMD, {24'h0, c});
		for (k = 0; k < 2000; k++) begin
			rd(RLS_STATUS);
			if (v[ST_BUSY] === 1'b0) break;
		end
		chk("idle", v[ST_BUSY], 0);
	endtask : op
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////////////////////////////
	task automatic t_power;
		chk("pins", {o_modem_data, o_ce_oe_n, o_sync_oe_n, o_serial_link_data_oe_n}, 4'hf);
		chk("osc", osc, 1);
		for (k = 0; k < 100 && o_ce !== 1'b1; k++) #8;
		chk("ce", {o_ce, o_ce_oe_n}, 2'b10);
		$display("power test done");
	endtask : t_power
	task automatic t_frames;
		op(32'h1234, 8'h05);
		chk("normal", frame, {7'h0, 3'b101, 1'b0, 5'd5, 16'h1234});
		chk("nlen", len, 25);
		s0 = nf;
		op(32'h15, 8'h83);
		chk("refused", nf, s0);
		wr(RLS_CTRL, 32'h1);
		op(32'h15, 8'h83);
		chk("f8", {len[7:0], frame[7:0]}, {8'd8, 3'd3, 5'h15});
		op(32'h0abc, 8'h42);
		chk("f16", {len[7:0], frame[15:0]}, {8'd16, 3'd2, 13'h0abc});
		$display("frame test done");
	endtask : t_frames
	task automatic t_wide;
		s0 = nf;
		op(32'hffff_dc04, 8'hd1);
		chk("wide", frame, {7'h0, 3'b101, 1'b0, 5'd17, 16'hdc04});
		chk("wnum", nf, s0 + 2);
		chk("gap", gap >= 480, 1);
		op(32'h0, 8'h31);
		rd(RLS_DATA);
		chk("count", v[15:0], 16'h0001);
		s0 = nf;
		op(32'h1, 8'hcc);
		chk("order", nf, s0);
		rd(RLS_STATUS);
		chk("oerr", v[ST_OERR], 1);
		$display("wide test done");
	endtask : t_wide
	task automatic t_sleep;
		wr(RLS_CTRL, 32'h33);
		for (k = 0; k < 50 && o_modem_data !== 1'b0; k++) #8;
		chk("modem", o_modem_data, 0);
		chk("sync", {o_sync, o_sync_oe_n}, 2'b10);
		wr(RLS_SLP_M, 32'h3);
		wr(RLS_SLP_N, 32'h2);
		@(posedge i_core_clk) i_hcc_en <= 1;
		wr(RLS_CTRL, 32'h7);
		#8 chk("local", o_domain_local, 1);
		wr(RLS_SLP_M, 32'h9);
		for (k = 0; k < 20 && o_clk_gate_req !== 1'b1; k++) #8;
		chk("req", {o_clk_gate_req, o_ce}, 2'b10);
		chk("osc off", osc, 0);
		for (k = 0; k < 50 && o_llc_clk_on !== 1'b0; k++) #8;
		s0 = sc;
		for (k = 0; k < 200 && o_clk_gate_req !== 1'b0; k++) #8;
		chk("m", sc - s0, 4);
		s0 = sc;
		for (k = 0; k < 200 && o_llc_clk_on !== 1'b1; k++) #8;
		chk("n", sc - s0, 3);
		for (k = 0; k < 5 && o_wakeup !== 1'b1; k++) #8;
		chk("wake", o_wakeup, 1);
		@(posedge i_core_clk) i_hcc_en <= 0;
		for (k = 0; k < 20 && o_domain_local !== 1'b0; k++) #8;
		rd(RLS_STATUS);
		chk("back", {o_domain_local, v[ST_WAKE]}, 2'b01);
		chk("osc on", osc, 1);
		rd(RLS_SLP_M);
		chk("lock", v, 32'h3);
		$display("sleep test done");
	endtask : t_sleep
	////////////////////////////////////////////////////////////////
	// Watchdog cuts a hang short
	initial begin
		#400000;
		errors++;
		report_and_stop;
	end
	initial begin
		i_arst_n = 0; i_wr = 0; i_rd = 0; i_addr = 0; i_wdata = 0; i_hcc_en = 0;
		errors = 0; checked = 0; sc = 0;
		repeat (20) @(posedge i_core_clk);
		i_arst_n <= 1;
		@(posedge i_core_clk);
		#1 t_power;
		t_frames;
		t_wide;
		t_sleep;
		report_and_stop;
	end
endmodule : tb
